// ===== verilog/init_seq_params.svh
`ifndef INIT_SEQ_PARAMS_SVH
`define INIT_SEQ_PARAMS_SVH

// =====================================================================
// Clock and timing
`define CLK_PERIOD_PS 25000
`define CAL_RUN_NS 1000
`define CAL_RUN_CYC ((`CAL_RUN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// =====================================================================
// Mode register addresses
`define MR_FEATURE_TWO 6'h02
`define MR_CMD_REF 6'h0C
`define MR_FUNC_OPT 6'h0D
`define MR_DQ_REF 6'h0E
`define MR_PATTERN 6'h20

// =====================================================================
// Field positions
`define WR_LEVEL_BIT 7
`define CMD_TRAIN_BIT 0

// =====================================================================
// Reset values
`define CMD_REF_RESET 7'h4D
`define DQ_REF_RESET 7'h4D
`define PATTERN_RESET 8'h5A
`define DRIVE_CODE_RESET 8'h00

`endif

// ===== verilog/init_seq_pkg.sv
`default_nettype none
package init_seq_pkg;

    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_MODE_WRITE = 4'h1,
        CMD_MODE_READ = 4'h2,
        CMD_CAL_START = 4'h3,
        CMD_CAL_LATCH = 4'h4,
        CMD_FIFO_WRITE = 4'h5,
        CMD_FIFO_READ = 4'h6,
        CMD_READ_CAL = 4'h7,
        CMD_ARRAY = 4'h8
    } cmd_kind_t;

    typedef struct packed {
        logic valid;
        cmd_kind_t kind;
        logic [5:0] addr;
        logic [7:0] op;
        logic [5:0] ca;
    } cmd_t;

    typedef enum logic [3:0] {
        ST_GATE_LOW = 4'b0000,
        ST_BOOT_IDLE = 4'b0001,
        ST_CAL_RUN = 4'b0011,
        ST_CAL_DONE = 4'b0010,
        ST_CMD_TRAIN = 4'b0110,
        ST_POST_CMD = 4'b0111,
        ST_WR_LEVEL = 4'b0101,
        ST_DQ_TRAIN = 4'b0100,
        ST_READY = 4'b1100
    } init_state_t;

    typedef struct packed {
        logic calibrated;
        logic cmd_high_speed;
        logic dq_high_speed;
        logic ready;
    } init_status_t;

endpackage : init_seq_pkg
`default_nettype wire

// ===== verilog/dram_power_up_init_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "init_seq_params.svh"

// Overview of operation
// - Data outputs undriven in reset or gate low.
// - Reset boots slow receivers, default reference.
// - Command training echoes CA and command reference on data.
// - FIFO training never touches array.
// - Array commands accepted once ready; mode writes accepted whenever gate is high, mode reads too except in command training and write leveling.
module dram_power_up_init_seq #(
    parameter int FIFO_DEPTH = 8,
    parameter int DQ_WIDTH = 16,
    parameter logic [7:0] CAL_CODE = 8'h3C
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic gate_pin_i,
    input wire logic wl_strobe_i,
    input var init_seq_pkg::cmd_t cmd_i,
    input wire logic [DQ_WIDTH-1:0] dq_i,
    output logic [DQ_WIDTH-1:0] dq_o,
    output logic dq_oe_n_o,
    output logic array_cmd_o,
    output logic [7:0] drive_code_o,
    output logic [6:0] cmd_ref_o,
    output logic [6:0] dq_ref_o,
    output init_seq_pkg::init_status_t status_o
);
    import init_seq_pkg::*;

    localparam int PTR_W = $clog2(FIFO_DEPTH);
    localparam logic [7:0] CAL_RUN_CYC = 8'(`CAL_RUN_CYC);

    // =================================================================
    // Pin synchronisers
    logic [2:0] gate_sync_reg, strobe_sync_reg;
    logic gate_reg, gate_next;
    logic strobe_reg, strobe_next;

    always_comb
    begin
        gate_next = gate_reg;
        strobe_next = strobe_reg;
        if (gate_sync_reg[1] == gate_sync_reg[2])
            gate_next = gate_sync_reg[2];
        if (strobe_sync_reg[1] == strobe_sync_reg[2])
            strobe_next = strobe_sync_reg[2];
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gate_sync_reg <= 3'h0;
            strobe_sync_reg <= 3'h0;
            gate_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end
        else
        begin
            gate_sync_reg <= {gate_sync_reg[1:0], gate_pin_i};
            strobe_sync_reg <= {strobe_sync_reg[1:0], wl_strobe_i};
            gate_reg <= gate_next;
            strobe_reg <= strobe_next;
        end
    end

    // =================================================================
    // Sequencer and mode state
    init_state_t state_reg, state_next;
    logic [7:0] cal_cnt_reg, cal_cnt_next;
    logic [7:0] drive_code_reg, drive_code_next;
    logic [6:0] cmd_ref_reg, cmd_ref_next;
    logic [6:0] dq_ref_reg, dq_ref_next;
    logic [7:0] pattern_reg, pattern_next;
    init_status_t status_reg, status_next;
    logic [DQ_WIDTH-1:0] dq_reg, dq_next;
    logic drive_reg, drive_next;
    logic array_reg, array_next;
    logic [DQ_WIDTH-1:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
    logic fifo_we;

    function automatic logic is_write(input cmd_t c, input logic [5:0] a);
        is_write = c.valid && c.kind == CMD_MODE_WRITE && c.addr == a;
    endfunction : is_write

    function automatic logic [7:0] mode_readback(input logic [5:0] a,
        input logic [6:0] cref, input logic [6:0] dref, input logic [7:0] pat);
        case (a)
            `MR_CMD_REF: mode_readback = {1'b0, cref};
            `MR_DQ_REF: mode_readback = {1'b0, dref};
            `MR_PATTERN: mode_readback = pat;
            default: mode_readback = 8'h00;
        endcase
    endfunction : mode_readback

    always_comb
    begin
        state_next = state_reg;
        cal_cnt_next = cal_cnt_reg;
        drive_code_next = drive_code_reg;
        cmd_ref_next = cmd_ref_reg;
        dq_ref_next = dq_ref_reg;
        pattern_next = pattern_reg;
        status_next = status_reg;
        dq_next = dq_reg;
        drive_next = 1'b0;
        array_next = 1'b0;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        fifo_we = 1'b0;
        // gate low forces data drive and array pulse off and restarts
        if (!gate_reg)
        begin
            state_next = ST_GATE_LOW;
            cal_cnt_next = 8'h00;
        end
        else
        begin
            if (is_write(cmd_i, `MR_CMD_REF))
                cmd_ref_next = cmd_i.op[6:0];
            if (is_write(cmd_i, `MR_DQ_REF))
                dq_ref_next = cmd_i.op[6:0];
            if (is_write(cmd_i, `MR_PATTERN))
                pattern_next = cmd_i.op;
            if (cmd_i.valid && cmd_i.kind == CMD_MODE_READ)
            begin
                dq_next = DQ_WIDTH'(mode_readback(cmd_i.addr, cmd_ref_reg,
                    dq_ref_reg, pattern_reg));
                drive_next = 1'b1;
            end
            case (state_reg)
                ST_GATE_LOW: state_next = ST_BOOT_IDLE;
                ST_BOOT_IDLE:
                begin
                    if (cmd_i.valid && cmd_i.kind == CMD_CAL_START)
                    begin
                        state_next = ST_CAL_RUN;
                        cal_cnt_next = 8'h00;
                    end
                end
                ST_CAL_RUN:
                begin
                    if (cal_cnt_reg < CAL_RUN_CYC)
                        cal_cnt_next = cal_cnt_reg + 8'h01;
                    else if (cmd_i.valid && cmd_i.kind == CMD_CAL_LATCH)
                    begin
                        drive_code_next = CAL_CODE;
                        status_next.calibrated = 1'b1;
                        state_next = ST_CAL_DONE;
                    end
                end
                ST_CAL_DONE:
                begin
                    if (is_write(cmd_i, `MR_FUNC_OPT) && cmd_i.op[`CMD_TRAIN_BIT])
                        state_next = ST_CMD_TRAIN;
                    else if (cmd_i.valid && cmd_i.kind == CMD_ARRAY)
                    begin
                        state_next = ST_READY;
                        status_next.ready = 1'b1;
                    end
                end
                ST_CMD_TRAIN:
                begin
                    dq_next = DQ_WIDTH'({cmd_ref_reg, 3'h0, cmd_i.ca});
                    drive_next = 1'b1;
                    if (is_write(cmd_i, `MR_FUNC_OPT) && !cmd_i.op[`CMD_TRAIN_BIT])
                    begin
                        status_next.cmd_high_speed = 1'b1;
                        state_next = ST_POST_CMD;
                    end
                end
                ST_POST_CMD:
                    if (is_write(cmd_i, `MR_FEATURE_TWO) && cmd_i.op[`WR_LEVEL_BIT])
                        state_next = ST_WR_LEVEL;
                ST_WR_LEVEL:
                begin
                    dq_next = DQ_WIDTH'(strobe_reg);
                    drive_next = 1'b1;
                    if (is_write(cmd_i, `MR_FEATURE_TWO) && !cmd_i.op[`WR_LEVEL_BIT])
                        state_next = ST_DQ_TRAIN;
                end
                ST_DQ_TRAIN:
                begin
                    if (cmd_i.valid && cmd_i.kind == CMD_FIFO_WRITE)
                    begin
                        fifo_we = 1'b1;
                        wr_ptr_next = wr_ptr_reg + PTR_W'(1);
                    end
                    else if (cmd_i.valid && cmd_i.kind == CMD_FIFO_READ)
                    begin
                        dq_next = fifo_mem[rd_ptr_reg];
                        drive_next = 1'b1;
                        rd_ptr_next = rd_ptr_reg + PTR_W'(1);
                    end
                    else if (cmd_i.valid && cmd_i.kind == CMD_READ_CAL)
                    begin
                        dq_next = DQ_WIDTH'({pattern_reg, pattern_reg});
                        drive_next = 1'b1;
                    end
                    else if (cmd_i.valid && cmd_i.kind == CMD_ARRAY)
                    begin
                        status_next.dq_high_speed = 1'b1;
                        status_next.ready = 1'b1;
                        state_next = ST_READY;
                    end
                end
                ST_READY:
                begin
                    array_next = cmd_i.valid && cmd_i.kind == CMD_ARRAY;
                end
                default: state_next = ST_GATE_LOW;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= ST_GATE_LOW;
            cal_cnt_reg <= 8'h00;
            drive_code_reg <= `DRIVE_CODE_RESET;
            cmd_ref_reg <= `CMD_REF_RESET;
            dq_ref_reg <= `DQ_REF_RESET;
            pattern_reg <= `PATTERN_RESET;
            status_reg <= '0;
            dq_reg <= '0;
            drive_reg <= 1'b0;
            array_reg <= 1'b0;
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cal_cnt_reg <= cal_cnt_next;
            drive_code_reg <= drive_code_next;
            cmd_ref_reg <= cmd_ref_next;
            dq_ref_reg <= dq_ref_next;
            pattern_reg <= pattern_next;
            status_reg <= status_next;
            dq_reg <= dq_next;
            drive_reg <= drive_next;
            array_reg <= array_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    // =================================================================
    // Training FIFO storage
    always_ff @(posedge clk_i)
    begin
        if (fifo_we)
            fifo_mem[wr_ptr_reg] <= dq_i;
    end

    // =================================================================
    // Outputs
    // drive only with gate high
    assign dq_oe_n_o = !(drive_reg && gate_reg);
    assign dq_o = dq_reg;
    assign array_cmd_o = array_reg;
    assign drive_code_o = drive_code_reg;
    assign cmd_ref_o = cmd_ref_reg;
    assign dq_ref_o = dq_ref_reg;
    assign status_o = status_reg;

endmodule : dram_power_up_init_seq
`default_nettype wire

// ===== verification/init_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Checker
module init_seq_checker
    import init_seq_pkg::*;
#(
    parameter int DQ_WIDTH = 16,
    parameter logic [7:0] CAL_CODE = 8'h3C
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic gate_pin_i,
    input wire logic wl_strobe_i,
    input var init_seq_pkg::cmd_t cmd_i,
    input wire logic [DQ_WIDTH-1:0] dq_i,
    input wire logic [DQ_WIDTH-1:0] dq_o,
    input wire logic dq_oe_n_o,
    input wire logic array_cmd_o,
    input wire logic [7:0] drive_code_o,
    input wire logic [6:0] cmd_ref_o,
    input wire logic [6:0] dq_ref_o,
    input var init_seq_pkg::init_status_t status_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_hiz_gate_low: assert property (!gate_pin_i [*5] |-> dq_oe_n_o)
        else $error("Data driven with gate low");
    a_code_values: assert property (drive_code_o == 8'h00 || drive_code_o == CAL_CODE)
        else $error("Drive code neither default nor calibrated");
    a_cal_applied: assert property (status_o.calibrated |-> drive_code_o == CAL_CODE)
        else $error("Calibrated flag without applied code");
    a_fast_after_cal: assert property ($rose(status_o.cmd_high_speed) |-> status_o.calibrated)
        else $error("High speed before calibration");
    a_reset_refs: assert property ($rose(rst_n_i) |-> cmd_ref_o == 7'h4D && dq_ref_o == 7'h4D)
        else $error("Reference not at default after reset");
    a_ready_read: assert property (gate_pin_i [*5] ##0 (status_o.ready && cmd_i.valid
        && cmd_i.kind == CMD_MODE_READ && cmd_i.addr == 6'h0E)
        |=> !dq_oe_n_o && dq_o[7:0] == {1'b0, $past(dq_ref_o)})
        else $error("Mode read not answered in ready");
    a_no_early_array: assert property (!status_o.calibrated |-> !array_cmd_o)
        else $error("Array command before calibration");
    a_train_no_array: assert property (cmd_i.valid && cmd_i.kind inside
        {CMD_FIFO_WRITE, CMD_FIFO_READ, CMD_READ_CAL} |=> !array_cmd_o)
        else $error("Training command reached array");
    cover property ($rose(status_o.calibrated));
    cover property (array_cmd_o);
    cover property ($rose(status_o.ready));
endmodule : init_seq_checker

bind dram_power_up_init_seq init_seq_checker #(.DQ_WIDTH(DQ_WIDTH), .CAL_CODE(CAL_CODE))
    init_seq_checker_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .gate_pin_i(gate_pin_i),
    .wl_strobe_i(wl_strobe_i), .cmd_i(cmd_i), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe_n_o(dq_oe_n_o), .array_cmd_o(array_cmd_o), .drive_code_o(drive_code_o),
    .cmd_ref_o(cmd_ref_o), .dq_ref_o(dq_ref_o), .status_o(status_o));
`default_nettype wire

// ===== verification/ctrl_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Controller pin sequencing
module ctrl_pin_model #(
    parameter int GATE_WAIT = 100
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic gate_en_i,
    input wire logic strobe_lvl_i,
    output logic gate_o,
    output logic strobe_o
);
    int cnt_reg;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= 0;
            gate_o <= 1'b0;
        end
        else
        begin
            cnt_reg <= (cnt_reg < GATE_WAIT) ? cnt_reg + 1 : cnt_reg;
            gate_o <= gate_en_i && cnt_reg >= GATE_WAIT;
        end
    end
    always_ff @(posedge clk_i)
    begin
        strobe_o <= strobe_lvl_i;
    end
endmodule : ctrl_pin_model
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) check(n, 16'(e), 16'(g))
// ========================================
// Bench
module testbench;
    import init_seq_pkg::*;
    localparam logic [7:0] CODE = 8'hC3;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic gate_en = 1'b0;
    logic strobe_lvl = 1'b0;
    logic gate_pin;
    logic wl_strobe;
    cmd_t cmd_i = '0;
    logic [15:0] dq_i = 16'h0000;
    logic [15:0] dq_o;
    logic dq_oe_n_o;
    logic array_cmd_o;
    logic [7:0] drive_code_o;
    logic [6:0] cmd_ref_o;
    logic [6:0] dq_ref_o;
    init_status_t status_o;
    int n_errors = 0;
    int tests_run = 0;
    always #12.5 clk_i = ~clk_i;
    ctrl_pin_model #(.GATE_WAIT(100)) ctrl_pin_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .gate_en_i(gate_en), .strobe_lvl_i(strobe_lvl), .gate_o(gate_pin), .strobe_o(wl_strobe));
    dram_power_up_init_seq #(.CAL_CODE(CODE)) dram_power_up_init_seq_inst (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .gate_pin_i(gate_pin), .wl_strobe_i(wl_strobe), .cmd_i(cmd_i),
        .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .array_cmd_o(array_cmd_o),
        .drive_code_o(drive_code_o), .cmd_ref_o(cmd_ref_o), .dq_ref_o(dq_ref_o),
        .status_o(status_o));
    task check(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            n_errors++;
        end
    endtask : check
    task end_of_test();
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task send(input cmd_kind_t k, input logic [5:0] a, input logic [7:0] op, input logic [5:0] c);
        @(posedge clk_i);
        cmd_i <= '{1'b1, k, a, op, c};
        @(posedge clk_i);
        cmd_i <= '0;
        #1;
    endtask : send
    task t_boot();
        cyc(185);
        `CHK("idle oe_n", 1'b1, dq_oe_n_o);
        `CHK("boot cmd ref", 7'h4D, cmd_ref_o);
        send(CMD_MODE_READ, 6'h0C, 8'h00, 6'h00);
        `CHK("boot read", 16'h004D, dq_o);
        `CHK("read oe_n", 1'b0, dq_oe_n_o);
        cyc(1);
        `CHK("read ends", 1'b1, dq_oe_n_o);
    endtask : t_boot
    task t_cal();
        send(CMD_MODE_WRITE, 6'h0B, 8'h00, 6'h00);
        send(CMD_CAL_START, 6'h00, 8'h00, 6'h00);
        cyc(8);
        send(CMD_CAL_LATCH, 6'h00, 8'h00, 6'h00);
        `CHK("early latch", 8'h00, drive_code_o);
        cyc(32);
        send(CMD_CAL_LATCH, 6'h00, 8'h00, 6'h00);
        `CHK("latched code", CODE, drive_code_o);
        `CHK("calibrated", 1'b1, status_o.calibrated);
        cyc(8);
    endtask : t_cal
    task t_train();
        send(CMD_MODE_WRITE, 6'h0D, 8'h01, 6'h00);
        send(CMD_NOP, 6'h00, 8'h00, 6'h2A);
        `CHK("ca echo", {7'h4D, 3'b000, 6'h2A}, dq_o);
        send(CMD_MODE_WRITE, 6'h0D, 8'h00, 6'h00);
        `CHK("cmd fast", 1'b1, status_o.cmd_high_speed);
        send(CMD_MODE_WRITE, 6'h02, 8'h80, 6'h00);
        @(posedge clk_i);
        strobe_lvl <= 1'b1;
        cyc(6);
        `CHK("level high", 16'h0001, dq_o);
        @(posedge clk_i);
        strobe_lvl <= 1'b0;
        cyc(6);
        `CHK("level low", 16'h0000, dq_o);
        send(CMD_MODE_WRITE, 6'h02, 8'h00, 6'h00);
        @(posedge clk_i);
        dq_i <= 16'hA5C3;
        send(CMD_FIFO_WRITE, 6'h00, 8'h00, 6'h00);
        send(CMD_FIFO_READ, 6'h00, 8'h00, 6'h00);
        `CHK("fifo read", 16'hA5C3, dq_o);
        send(CMD_MODE_WRITE, 6'h20, 8'h96, 6'h00);
        send(CMD_READ_CAL, 6'h00, 8'h00, 6'h00);
        `CHK("read cal", 16'h9696, dq_o);
        send(CMD_MODE_WRITE, 6'h0E, 8'h33, 6'h00);
        `CHK("dq ref", 7'h33, dq_ref_o);
        `CHK("array idle", 1'b0, array_cmd_o);
    endtask : t_train
    task t_ready();
        send(CMD_ARRAY, 6'h00, 8'h00, 6'h00);
        `CHK("ready", 1'b1, status_o.ready);
        `CHK("dq fast", 1'b1, status_o.dq_high_speed);
        send(CMD_ARRAY, 6'h00, 8'h00, 6'h00);
        `CHK("array pulse", 1'b1, array_cmd_o);
        send(CMD_MODE_READ, 6'h0E, 8'h00, 6'h00);
        `CHK("ready read", 16'h0033, dq_o);
        `CHK("pulse ends", 1'b0, array_cmd_o);
        send(CMD_MODE_WRITE, 6'h0C, 8'h21, 6'h00);
        `CHK("cmd ref", 7'h21, cmd_ref_o);
    endtask : t_ready
    task t_off_reset();
        @(posedge clk_i);
        gate_en <= 1'b0;
        cyc(6);
        send(CMD_MODE_READ, 6'h0E, 8'h00, 6'h00);
        `CHK("off hi-z", 1'b1, dq_oe_n_o);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        cyc(4);
        `CHK("status clear", 4'h0, status_o);
        `CHK("ref default", 7'h4D, dq_ref_o);
        `CHK("reset oe_n", 1'b1, dq_oe_n_o);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        gate_en <= 1'b1;
    endtask : t_off_reset
    initial
    begin
        cyc(2);
        `CHK("reset drive", 8'h00, drive_code_o);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        gate_en <= 1'b1;
        t_boot();
        t_cal();
        t_train();
        t_ready();
        t_off_reset();
        t_boot();
        end_of_test();
    end
    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
